/* src/failsafe_release_standby_bist.sv */
// Fail-safe release, standby entry and self-test sequencing.
// Assumes a register port decoded from the serial bus and open-drain pads outside.
`timescale 1ns/1ns
`default_nettype none
`include "fs_defines.svh"
module failsafe_release_standby_bist
  import fs_pkg::*;
#(
  parameter int LOGIC_SELFTEST_CYC  = `LOGIC_SELFTEST_US * `CLK_MHZ,
  parameter int DELAY_CYC  = `RDELAY_US * `CLK_MHZ,
  parameter int SHORT_CYC  = `SHORT_US * `CLK_MHZ,
  parameter int RPULSE_CYC = `RPULSE_US * `CLK_MHZ
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [5:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  output var  logic [15:0] reg_rdata_o,
  input  wire logic [15:0] watchdog_seed_value_i,
  input  wire logic        failsafe_init_phase_i,
  input  wire logic        err_cnt_dec_i,
  input  wire logic [7:0]  fault_i,
  input  wire logic        wake_i,
  input  wire logic        logic_selftest_fail_i,
  input  wire logic [3:0]  monitor_fail_i,
  input  wire logic        osc_fail_i,
  input  wire logic        digital_supply_ov_i,
  input  wire logic [3:0]  analog_selftest_first_assign_cfg_i,
  input  wire logic        standby_polarity_cfg_i,
  input  wire logic        standby_enable_cfg_i,
  input  wire logic        standby_safety_path_disable_cfg_i,
  input  wire logic        standby_window_enable_cfg_i,
  input  wire logic        reset_release_delay_cfg_i,
  input  wire logic        standby_in_i,
  input  wire logic        safe_state_in_i,
  input  wire logic        reset_in_n_i,
  input  wire logic        power_good_in_i,
  output var  logic        safe_state_out_o,
  output var  logic        safe_state_out_oe_o,
  output var  logic        reset_out_n_o,
  output var  logic        reset_out_n_oe_o,
  output var  logic        power_good_out_o,
  output var  logic        power_good_out_oe_o,
  output var  logic        standby_enter_o
);
  localparam int ABIST_CYC = `ABIST_US * `CLK_MHZ;
  localparam logic [`TMR_W-1:0] LB_END = `TMR_W'(LOGIC_SELFTEST_CYC - 1);
  localparam logic [`TMR_W-1:0] AB_END = `TMR_W'(ABIST_CYC - 1);
  localparam logic [`TMR_W-1:0] DL_END = `TMR_W'(DELAY_CYC - 1);
  localparam logic [`TMR_W-1:0] SH_END = `TMR_W'(SHORT_CYC - 1);
  localparam logic [`TMR_W-1:0] RP_END = `TMR_W'(RPULSE_CYC - 1);

  fs_state_t q_r;
  fs_state_t q_nxt;
  logic [15:0] key_exp;

  // ----------------------------------------
  // Window decode
  // ----------------------------------------
  function automatic logic [`TMR_W-1:0] win_cycles(input logic [3:0] dur);
    logic [`TMR_W-1:0] c;
    c = '0;
    case (dur)
      4'h4: c = `TMR_W'(60 * `CLK_MHZ);
      4'h5: c = `TMR_W'(80 * `CLK_MHZ);
      4'h6: c = `TMR_W'(100 * `CLK_MHZ);
      4'h7: c = `TMR_W'(200 * `CLK_MHZ);
      4'h8: c = `TMR_W'(300 * `CLK_MHZ);
      4'h9: c = `TMR_W'(500 * `CLK_MHZ);
      4'ha: c = `TMR_W'(1000 * `CLK_MHZ);
      4'hb: c = `TMR_W'(2000 * `CLK_MHZ);
      4'hc: c = `TMR_W'(3000 * `CLK_MHZ);
      4'hd: c = `TMR_W'(5000 * `CLK_MHZ);
      4'he: c = `TMR_W'(8000 * `CLK_MHZ);
      4'hf: c = `TMR_W'(10000 * `CLK_MHZ);
      default: c = '0;
    endcase
    return c;
  endfunction

  // ----------------------------------------
  // Expected release key
  // ----------------------------------------
  for (genvar i = 0; i < 16; i++) begin : g_key
    assign key_exp[i] = ~watchdog_seed_value_i[15-i];
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic standby_in_lvl;
    logic standby_in_edge;
    logic inc;
    logic viol;
    logic win_on;
    logic ab1_err;
    logic wr_key;
    standby_in_lvl = 1'b0;
    standby_in_edge = 1'b0;
    inc = 1'b0;
    viol = 1'b0;
    win_on = 1'b0;
    ab1_err = 1'b0;
    wr_key = 1'b0;
    q_nxt = q_r;
    q_nxt.standby_in_enter = 1'b0;
    q_nxt.od_lvl = 1'b0;
    q_nxt.standby_in_s = {q_r.standby_in_s[0], standby_in_i};
    q_nxt.safe_s = {q_r.safe_s[0], safe_state_in_i};
    q_nxt.rst_s = {q_r.rst_s[0], reset_in_n_i};
    q_nxt.pg_s = {q_r.pg_s[0], power_good_in_i};
    standby_in_lvl = standby_polarity_cfg_i ? q_r.standby_in_s[1] : ~q_r.standby_in_s[1];
    q_nxt.standby_in_prev = standby_in_lvl;
    standby_in_edge = standby_enable_cfg_i & standby_in_lvl & ~q_r.standby_in_prev;
    win_on = standby_window_enable_cfg_i & (q_r.win_dur >= `WIN_FIRST);
    ab1_err = osc_fail_i | digital_supply_ov_i | q_r.safe_s[1];
    ab1_err = ab1_err | (|(monitor_fail_i & analog_selftest_first_assign_cfg_i));
    if (q_r.wake) begin
      ab1_err = ab1_err | ~q_r.rst_s[1] | ~q_r.pg_s[1];
    end else begin
      ab1_err = ab1_err | q_r.rst_s[1] | q_r.pg_s[1];
    end
    case (q_r.state)
      ST_LOGIC_SELFTEST: begin
        q_nxt.timer = q_r.timer + 1'b1;
        if (q_r.timer == LB_END) begin
          q_nxt.logic_selftest_ok = ~logic_selftest_fail_i;
          q_nxt.timer = '0;
          q_nxt.state = ST_ANALOG_SELFTEST_FIRST;
        end
      end
      ST_ANALOG_SELFTEST_FIRST: begin
        q_nxt.timer = q_r.timer + 1'b1;
        if (q_r.timer == AB_END) begin
          q_nxt.ab1_ok = ~ab1_err;
          q_nxt.timer = '0;
          if (reset_release_delay_cfg_i) begin
            q_nxt.state = ST_DELAY;
          end else begin
            q_nxt.state = ST_RUN;
            q_nxt.pg_low = 1'b0;
          end
        end
      end
      ST_DELAY: begin
        q_nxt.timer = q_r.timer + 1'b1;
        if (q_r.timer == DL_END) begin
          q_nxt.timer = '0;
          q_nxt.state = ST_RUN;
          q_nxt.pg_low = 1'b0;
        end
      end
      ST_RUN: begin
        if (!q_r.pg_low) begin
          q_nxt.rst_low = 1'b0;
        end
        if (q_r.standby_request_bit && win_on && !standby_safety_path_disable_cfg_i) begin
          q_nxt.win_tmr = q_r.win_tmr + 1'b1;
          if (q_r.win_tmr >= win_cycles(q_r.win_dur)) begin
            viol = 1'b1;
          end
        end
        if (viol) begin
          inc = 1'b1;
          q_nxt.standby_request_bit = 1'b0;
          q_nxt.win_tmr = '0;
          q_nxt.rst_low = 1'b1;
          q_nxt.timer = '0;
          q_nxt.state = ST_RPULSE;
        end else if (standby_in_edge && (standby_safety_path_disable_cfg_i || q_r.standby_request_bit)) begin
          q_nxt.standby_in_enter = 1'b1;
          q_nxt.standby_request_bit = 1'b0;
          q_nxt.win_tmr = '0;
          q_nxt.safe_low = 1'b1;
          q_nxt.state = ST_STANDBY_IN;
        end
      end
      ST_RPULSE: begin
        q_nxt.timer = q_r.timer + 1'b1;
        if (q_r.timer == RP_END) begin
          q_nxt.timer = '0;
          q_nxt.state = ST_RUN;
        end
      end
      ST_STANDBY_IN: begin
        if (wake_i) begin
          q_nxt.wake = 1'b1;
          q_nxt.cnt = `CNT_INIT;
          q_nxt.logic_selftest_ok = 1'b0;
          q_nxt.ab1_ok = 1'b0;
          q_nxt.ab2_ok = 1'b0;
          q_nxt.timer = '0;
          q_nxt.state = ST_LOGIC_SELFTEST;
        end
      end
      default: begin
        q_nxt.state = ST_LOGIC_SELFTEST;
        q_nxt.timer = '0;
      end
    endcase
    // Register writes
    wr_key = reg_wr_i && (reg_addr_i == `ADR_KEY);
    if (wr_key && (reg_wdata_i == key_exp) && q_r.state == ST_RUN && !q_r.rst_low) begin
      if (q_r.logic_selftest_ok && q_r.ab1_ok && q_r.ab2_ok) begin
        if (q_r.cnt == `CNT_ZERO) begin
          q_nxt.safe_low = 1'b0;
        end
      end
    end
    if (reg_wr_i && reg_addr_i == `ADR_REACT && failsafe_init_phase_i) begin
      q_nxt.react = reg_wdata_i[7:0];
    end
    if (reg_wr_i && reg_addr_i == `ADR_SAFEIN && failsafe_init_phase_i) begin
      q_nxt.win_dur = reg_wdata_i[3:0];
    end
    if (reg_wr_i && reg_addr_i == `ADR_AB2 && !failsafe_init_phase_i) begin
      q_nxt.ab2_sel = reg_wdata_i[3:0];
      q_nxt.ab2_ok = ~|(reg_wdata_i[3:0] & monitor_fail_i);
    end
    if (reg_wr_i && reg_addr_i == `ADR_IOS && reg_wdata_i[`IOS_REQ]) begin
      q_nxt.standby_request_bit = 1'b1;
      q_nxt.win_tmr = '0;
    end
    // Configured faults and short to high
    if (|(fault_i & q_r.react)) begin
      q_nxt.safe_low = 1'b1;
      inc = 1'b1;
    end
    if (q_r.safe_low && q_r.safe_s[1]) begin
      if (q_r.sh_tmr == SH_END) begin
        if (!q_r.sh_flag) begin
          inc = 1'b1;
        end
        q_nxt.sh_flag = 1'b1;
      end else begin
        q_nxt.sh_tmr = q_r.sh_tmr + 1'b1;
      end
    end else begin
      q_nxt.sh_tmr = '0;
    end
    // Fault error count, increment wins over decrement
    if (q_r.state == ST_STANDBY_IN && wake_i) begin
      q_nxt.cnt = `CNT_INIT;
    end else if (inc) begin
      if (q_r.cnt != `CNT_MAX) begin
        q_nxt.cnt = q_r.cnt + 1'b1;
      end
    end else if (err_cnt_dec_i && q_r.cnt != `CNT_ZERO) begin
      q_nxt.cnt = q_r.cnt - 1'b1;
    end
    // Register reads
    if (reg_rd_i) begin
      q_nxt.rd_data = '0;
      case (reg_addr_i)
        `ADR_REACT: q_nxt.rd_data[7:0] = q_r.react;
        `ADR_AB2: q_nxt.rd_data[3:0] = q_r.ab2_sel;
        `ADR_SAFEIN: q_nxt.rd_data[3:0] = q_r.win_dur;
        `ADR_IOS: begin
          q_nxt.rd_data[`IOS_REQ] = q_r.standby_request_bit;
          q_nxt.rd_data[`IOS_SAFE] = q_r.safe_low;
        end
        `ADR_DIAG: begin
          q_nxt.rd_data[`DIAG_LB] = q_r.logic_selftest_ok;
          q_nxt.rd_data[`DIAG_AB1] = q_r.ab1_ok;
          q_nxt.rd_data[`DIAG_AB2] = q_r.ab2_ok;
          q_nxt.rd_data[`DIAG_SH] = q_r.sh_flag;
          q_nxt.rd_data[`DIAG_CNT] = q_r.cnt;
        end
        default: q_nxt.rd_data = '0;
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      q_r <= '0;
      q_r.state <= ST_LOGIC_SELFTEST;
      q_r.cnt <= `CNT_INIT;
      q_r.win_dur <= `WIN_DEFAULT;
      q_r.safe_low <= 1'b1;
      q_r.rst_low <= 1'b1;
      q_r.pg_low <= 1'b1;
    end else begin
      q_r <= q_nxt;
    end
  end

  assign reg_rdata_o = q_r.rd_data;
  assign safe_state_out_o = q_r.od_lvl;
  assign safe_state_out_oe_o = q_r.safe_low;
  assign reset_out_n_o = q_r.od_lvl;
  assign reset_out_n_oe_o = q_r.rst_low;
  assign power_good_out_o = q_r.od_lvl;
  assign power_good_out_oe_o = q_r.pg_low;
  assign standby_enter_o = q_r.standby_in_enter;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  rel_bist_a: assert property ($fell(q_r.safe_low) |-> $past(q_r.logic_selftest_ok && q_r.ab1_ok && q_r.ab2_ok))
    else $error("safe output released with a failed self-test");
  rel_cnt_a: assert property ($fell(q_r.safe_low) |-> $past(q_r.cnt) == `CNT_ZERO)
    else $error("safe output released with nonzero count");
  rel_key_a: assert property ($fell(q_r.safe_low) |->
      $past(reg_wr_i && reg_addr_i == `ADR_KEY && reg_wdata_i == key_exp))
    else $error("safe output released without matching key");
  short_filt_a: assert property ($rose(q_r.sh_flag) |-> $past(q_r.sh_tmr) == SH_END && $past(q_r.safe_low))
    else $error("short flag set before filter time");
  win_lock_a: assert property (reg_wr_i && reg_addr_i == `ADR_SAFEIN && !failsafe_init_phase_i
      |=> $stable(q_r.win_dur))
    else $error("window field changed outside init");
  standby_in_en_a: assert property (q_r.standby_in_enter |-> $past(standby_enable_cfg_i))
    else $error("standby entered while disabled");
  rst_order_a: assert property ($fell(q_r.rst_low) |-> !$past(q_r.pg_low) && q_r.state == ST_RUN)
    else $error("reset released before power-good");
  logic_selftest_time_a: assert property (q_r.state == ST_LOGIC_SELFTEST |-> q_r.timer <= LB_END)
    else $error("logic self-test overran");
  viol_pulse_a: assert property ($rose(q_r.state == ST_RPULSE) |-> q_r.rst_low && $stable(q_r.safe_low))
    else $error("window violation reaction wrong");
endmodule
`default_nettype wire

/* src/fs_defines.svh */
// Constants of the fail-safe release, standby and self-test block.
// Assumes a 20 MHz clock and the register port of the fail-safe logic.
// How it works
// - Safe output released only if logic and both analog self-test flags are 1.
// - Release also needs the fault error count at zero.
// - Release key must equal the watchdog seed reversed and inverted.
// - Safe output held high while driven low flagged after 500 us filter.
// - Configurable faults assert safe output per reaction bits written in init.
// - Polarity setting selects standby active high or active low.
// - Standby input works only when its enable setting is set.
// - Standard path: pin alone enters standby; safety path needs request first.
// - Safety path with window enabled times request to pin transition.
// - Window field: 0 off, 1-3 reserved, 4-15 from 60 us to 10 ms.
// - Window field writable only in init phase, later writes ignored.
// - Logic self-test runs after power-on and every wake-up.
// - Logic self-test fail releases reset and power-good, safe output stays low.
// - Logic self-test lasts 3 ms, never above 5 ms.
// - First analog self-test runs after power-on and wake, checks assigned monitors.
// - After init, per-monitor select bits request the second analog self-test.
// - Analog self-test fail keeps safe output low; both results readable.
// - On wake, reset or power-good pin low is a first analog self-test error.
// - First analog test covers oscillator, digital supply and pin shorts always.
// - Delay setting adds 5 ms before reset and power-good release.
// - Fault error count starts at one after power-on and wake.
// - Window violation increments count, pulses reset, leaves safe output alone.
// - Reset released only after power-good release and first analog test.
`ifndef FS_DEFINES_SVH
`define FS_DEFINES_SVH
`define CLK_MHZ 20
`define LOGIC_SELFTEST_US 3000
`define ABIST_US 200
`define RDELAY_US 5000
`define SHORT_US 500
`define RPULSE_US 1000
`define TMR_W 18
`define CNT_INIT 4'h1
`define CNT_MAX 4'hf
`define CNT_ZERO 4'h0
`define WIN_DEFAULT 4'ha
`define WIN_FIRST 4'h4
`define ADR_REACT 6'h01
`define ADR_AB2 6'h05
`define ADR_SAFEIN 6'h09
`define ADR_KEY 6'h14
`define ADR_IOS 6'h15
`define ADR_DIAG 6'h16
`define IOS_REQ 0
`define IOS_SAFE 1
`define DIAG_LB 0
`define DIAG_AB1 1
`define DIAG_AB2 2
`define DIAG_SH 3
`define DIAG_CNT 7:4
`endif

/* src/fs_pkg.sv */
// Types of the fail-safe release, standby and self-test block.
// Assumes fs_defines.svh for widths.
`include "fs_defines.svh"
package fs_pkg;
  typedef enum logic [5:0] {
    ST_LOGIC_SELFTEST  = 6'h01,
    ST_ANALOG_SELFTEST_FIRST = 6'h02,
    ST_DELAY  = 6'h04,
    ST_RUN    = 6'h08,
    ST_RPULSE = 6'h10,
    ST_STANDBY_IN   = 6'h20
  } state_t;
  typedef struct packed {
    state_t            state;
    logic [`TMR_W-1:0] timer;
    logic [`TMR_W-1:0] win_tmr;
    logic [`TMR_W-1:0] sh_tmr;
    logic [3:0]        cnt;
    logic              logic_selftest_ok;
    logic              ab1_ok;
    logic              ab2_ok;
    logic [3:0]        ab2_sel;
    logic [3:0]        win_dur;
    logic [7:0]        react;
    logic              standby_request_bit;
    logic              safe_low;
    logic              rst_low;
    logic              pg_low;
    logic              standby_in_enter;
    logic              standby_in_prev;
    logic              wake;
    logic              sh_flag;
    logic              od_lvl;
    logic [15:0]       rd_data;
    logic [1:0]        standby_in_s;
    logic [1:0]        safe_s;
    logic [1:0]        rst_s;
    logic [1:0]        pg_s;
  } fs_state_t;
endpackage

/* tb/mcu_model.sv */
// Far-side controller: standby pin driver and pull-ups on the open-drain safety pins.
// Assumes the bench commands the standby level and an external stuck-high fault.
`timescale 1ns/1ns
`default_nettype none
module mcu_model (
  input  wire logic clk_i,
  input  wire logic standby_in_cmd_i,
  input  wire logic stuck_i,
  input  wire logic safe_oe_i,
  input  wire logic rst_oe_i,
  input  wire logic pg_oe_i,
  output var  logic standby_pin_o,
  output var  logic safe_pin_o,
  output var  logic rst_pin_o,
  output var  logic pg_pin_o
);
  // ----------------------------------------
  // Standby pin, moved on the rising edge
  // ----------------------------------------
  initial standby_pin_o = 1'b0;
  always @(posedge clk_i) standby_pin_o <= standby_in_cmd_i;
  // ----------------------------------------
  // Pull-ups win unless a pin is pulled low
  // ----------------------------------------
  assign safe_pin_o = stuck_i | ~safe_oe_i;
  assign rst_pin_o  = ~rst_oe_i;
  assign pg_pin_o   = ~pg_oe_i;
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench of the fail-safe release, standby and self-test block.
// Assumes fs_pkg and the controller model; short parameters for long counts.
`timescale 1ns/1ns
`default_nettype none
module tb;
  import fs_pkg::*;
  localparam int LB = 20;
  localparam int DLY = 10;
  localparam int SH = 8;
  localparam int RP = 8;
  logic        clk_i, rst_b_i, reg_wr_i, reg_rd_i, dec, wake, lb_fail, init_ph, osc, ov;
  logic        pol, en, sdis, wen, dly, standby_in_cmd, stuck, standby_in_pin, safe_pin, rst_pin, pg_pin;
  logic        safe_oe, rst_oe, pg_oe, standby_in_enter;
  logic [5:0]  reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, seed, rd_v;
  logic [7:0]  fault;
  logic [3:0]  mon_fail, assign_cfg;
  logic [2:0]  od;
  logic [31:0] lfsr_s;
  int          errors, tests_run, cyc, m_cnt, m_flags, n, t0;

  failsafe_release_standby_bist #(.LOGIC_SELFTEST_CYC(LB), .DELAY_CYC(DLY), .SHORT_CYC(SH), .RPULSE_CYC(RP)) DUT (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .watchdog_seed_value_i(seed), .failsafe_init_phase_i(init_ph), .err_cnt_dec_i(dec),
    .fault_i(fault), .wake_i(wake), .logic_selftest_fail_i(lb_fail), .monitor_fail_i(mon_fail),
    .osc_fail_i(osc), .digital_supply_ov_i(ov), .analog_selftest_first_assign_cfg_i(assign_cfg),
    .standby_polarity_cfg_i(pol), .standby_enable_cfg_i(en), .standby_safety_path_disable_cfg_i(sdis),
    .standby_window_enable_cfg_i(wen), .reset_release_delay_cfg_i(dly), .standby_in_i(standby_in_pin),
    .safe_state_in_i(safe_pin), .reset_in_n_i(rst_pin), .power_good_in_i(pg_pin),
    .safe_state_out_o(od[0]), .safe_state_out_oe_o(safe_oe), .reset_out_n_o(od[1]), .reset_out_n_oe_o(rst_oe),
    .power_good_out_o(od[2]), .power_good_out_oe_o(pg_oe), .standby_enter_o(standby_in_enter));

  mcu_model mcu (.clk_i(clk_i), .standby_in_cmd_i(standby_in_cmd), .stuck_i(stuck), .safe_oe_i(safe_oe),
    .rst_oe_i(rst_oe), .pg_oe_i(pg_oe), .standby_pin_o(standby_in_pin), .safe_pin_o(safe_pin),
    .rst_pin_o(rst_pin), .pg_pin_o(pg_pin));

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 30000) begin
      errors++;
      summarize();
    end
  end

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] key_of(input logic [15:0] s);
    for (int i = 0; i < 16; i++) key_of[15-i] = ~s[i];
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(negedge clk_i);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(negedge clk_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic diag(input logic [15:0] mask);
    @(negedge clk_i);
    reg_rd_i = 1'b1;
    reg_addr_i = 6'h16;
    @(negedge clk_i);
    reg_rd_i = 1'b0;
    @(negedge clk_i);
    rd_v = reg_rdata_o;
    chk(rd_v & mask, 16'((m_cnt << 4) | m_flags) & mask);
  endtask
  task automatic wait_lvl(ref logic s, input logic v, input int lim, output int k);
    k = 0;
    while (s !== v && k < lim) begin
      @(negedge clk_i);
      k++;
    end
  endtask
  task automatic pulse(ref logic s);
    @(negedge clk_i);
    s = 1'b1;
    @(negedge clk_i);
    s = 1'b0;
  endtask
  task automatic try_key(input logic [15:0] flip, input logic exp_oe);
    lfsr_s = lfsr(lfsr_s);
    seed = lfsr_s[15:0];
    wr(6'h14, key_of(seed) ^ flip);
    repeat (2) @(negedge clk_i);
    chk(16'(safe_oe), 16'(exp_oe));
  endtask
  task automatic put_fault(input logic [7:0] f, input logic exp_oe);
    @(negedge clk_i);
    fault = f;
    @(negedge clk_i);
    fault = 8'h00;
    @(negedge clk_i);
    chk(16'(safe_oe), 16'(exp_oe));
  endtask
  task automatic summarize;
    $display("Comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    {rst_b_i, reg_wr_i, reg_rd_i, dec, wake, lb_fail, osc, ov, sdis, standby_in_cmd, stuck} = '0;
    {pol, en, wen, dly, init_ph} = 5'h1f;
    reg_addr_i = 6'h00;
    reg_wdata_i = 16'h0000;
    fault = 8'h00;
    mon_fail = 4'h0;
    assign_cfg = 4'hf;
    lfsr_s = 32'h1af9f0bd;
    seed = lfsr_s[15:0];
    {errors, tests_run, cyc, m_flags} = '0;
    m_cnt = 1;
    repeat (8) @(negedge clk_i);
    rst_b_i = 1'b1;
    t0 = cyc;
    wr(6'h01, 16'h0001);
    wr(6'h09, 16'h0004);
    wait_lvl(rst_oe, 1'b0, 6000, n);
    chk(16'(cyc - t0 >= LB + 4000 + DLY), 16'h0001);
    chk(16'(pg_oe), 16'h0000);
    chk(16'(safe_oe), 16'h0001);
    m_flags = 3;
    diag(16'hffff);
    init_ph = 1'b0;
    wr(6'h05, 16'h000f);
    m_flags = 7;
    diag(16'hffff);
    try_key(16'h0000, 1'b1);
    pulse(dec);
    m_cnt = 0;
    try_key(16'h0100, 1'b1);
    try_key(16'h0000, 1'b0);
    put_fault(8'h02, 1'b0);
    put_fault(8'h01, 1'b1);
    m_cnt = 1;
    stuck = 1'b1;
    repeat (SH + 6) @(negedge clk_i);
    stuck = 1'b0;
    m_cnt = 2;
    m_flags = 15;
    diag(16'hffff);
    wr(6'h09, 16'h0000);
    wr(6'h15, 16'h0001);
    wait_lvl(rst_oe, 1'b1, 1400, n);
    chk(16'(n >= 1190 && n <= 1210), 16'h0001);
    chk(16'(safe_oe), 16'h0001);
    wait_lvl(rst_oe, 1'b0, 40, n);
    m_cnt = 3;
    diag(16'hffff);
    standby_in_cmd = 1'b1;
    wait_lvl(standby_in_enter, 1'b1, 10, n);
    chk(16'(n), 16'd10);
    standby_in_cmd = 1'b0;
    repeat (4) @(negedge clk_i);
    wr(6'h15, 16'h0001);
    standby_in_cmd = 1'b1;
    wait_lvl(standby_in_enter, 1'b1, 10, n);
    chk(16'(standby_in_enter), 16'h0001);
    standby_in_cmd = 1'b0;
    pulse(wake);
    repeat (LB + 4000 + DLY + 20) @(negedge clk_i);
    m_cnt = 1;
    diag(16'hfff3);
    chk(16'(rst_oe), 16'h0000);
    rst_b_i = 1'b0;
    lb_fail = 1'b1;
    dly = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_b_i = 1'b1;
    wait_lvl(rst_oe, 1'b0, 6000, n);
    chk(16'(n >= LB + 4000 && n <= LB + 4004), 16'h0001);
    chk(16'(rst_oe | pg_oe), 16'h0000);
    chk(16'(od), 16'h0000);
    mon_fail = 4'h1;
    wr(6'h05, 16'h0001);
    mon_fail = 4'h0;
    m_flags = 2;
    diag(16'h00f7);
    pulse(dec);
    try_key(16'h0000, 1'b1);
    {en, pol, sdis} = 3'h1;
    wait_lvl(standby_in_enter, 1'b1, 6, n);
    chk(16'(n), 16'd6);
    pol = 1'b1;
    repeat (4) @(negedge clk_i);
    {en, pol} = 2'h2;
    wait_lvl(standby_in_enter, 1'b1, 10, n);
    chk(16'(standby_in_enter), 16'h0001);
    summarize();
  end
endmodule
`default_nettype wire
